// File: sim/adcs_ana_model.sv
// analog source model: per-channel input level compared against the trial code
module adcs_ana_model (
  // selection and trial code
  input  wire logic [3:0] chan_i,
  input  wire logic [9:0] dac_i,
  input  wire logic [9:0] bias_i,
  // comparator
  output logic            comp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bias lets the bench move every level between conversions
  assign comp_o = ((10'(chan_i * 10'h03B) ^ bias_i) >= dac_i);
endmodule // adcs_ana_model

// File: sim/adcs_sva.sv
// concurrent checks on the sequencer ports
module adcs_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // watched ports
  input wire logic        standby_i,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  channel_select_o,
  input wire logic        sample_o,
  input wire logic        ladder_on_o,
  input wire logic        conv_done_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // three cycles lets the one- and two-cycle-late outputs settle
  sequence s_standby_held;
    standby_i [*3];
  endsequence
  a_irq_one_cycle: assert property (conv_done_irq_o |=> !conv_done_irq_o [*8])
    else $error("done interrupt not a single pulse");
  a_irq_after_trial: assert property (sample_o |=> !conv_done_irq_o)
    else $error("completion straight after sampling");
  a_standby_ladder: assert property (s_standby_held |-> !ladder_on_o)
    else $error("ladder connected in standby");
  a_standby_idle: assert property (s_standby_held |-> !sample_o && !conv_done_irq_o)
    else $error("activity in standby");
  a_standby_chan: assert property (s_standby_held |-> channel_select_o == 4'h0)
    else $error("channel not reset in standby");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
endmodule // adcs_sva

bind adcs_top adcs_sva u_sva (.clk_i, .rst_n_i, .standby_i, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .channel_select_o, .sample_o,
  .ladder_on_o, .conv_done_irq_o);

// File: sim/tb_top.sv
// self-checking bench for the conversion sequencer
`include "adcs_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A1 = 10'(`ADCS_IDX_CTRL1 * 4);
  localparam logic [9:0] A2 = 10'(`ADCS_IDX_CTRL2 * 4);
  localparam logic [9:0] AH = 10'(`ADCS_IDX_RES_HIGH * 4);
  localparam logic [9:0] AL = 10'(`ADCS_IDX_RES_LOW * 4);
  logic        clk_i, rst_n_i, standby_i, comp_i, s_axi_awvalid, s_axi_wvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, analog_input_disable_o;
  logic        sample_o, ladder_on_o, conv_done_irq_o;
  logic [9:0]  s_axi_awaddr, s_axi_araddr, dac_code_o, bias, prev;
  logic [31:0] s_axi_wdata, s_axi_rdata, rval;
  logic [3:0]  s_axi_wstrb, channel_select_o, ch;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, wrsp;
  int          mismatches, checks, seed, irq_cnt, n0;
  time         t0, t_irq;

  adcs_top dut (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .standby_i, .comp_i, .channel_select_o, .analog_input_disable_o,
    .dac_code_o, .sample_o, .ladder_on_o, .conv_done_irq_o);
  adcs_ana_model u_ana (.chan_i(channel_select_o), .dac_i(dac_code_o), .bias_i(bias),
    .comp_o(comp_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (conv_done_irq_o) begin
    irq_cnt <= irq_cnt + 1;
    t_irq = $time;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hung(input int n);
    if (n >= 3000) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 3000);
    s_axi_bready <= 1'b0;
    wrsp = s_axi_bresp;
    hung(n);
  endtask
  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 3000);
    s_axi_rready <= 1'b0;
    rval = s_axi_rdata;
    rsp = s_axi_rresp;
    hung(n);
  endtask
  task automatic chk_rd(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rval, {24'h00_0000, e});
    `CHK(rsp, `ADCS_RESP_OKAY);
  endtask
  task automatic wait_irq(input int c0);
    int k;
    for (k = 0; k < 3000 && irq_cnt == c0; k++) @(posedge clk_i);
    hung(k);
  endtask
  function automatic int cyc(input logic [2:0] c);
    return (c == 3'h0) ? 39 : (c == 3'h1 || c == 3'h7) ? 1248 : 39 << (c - 1);
  endfunction
  function automatic logic [9:0] vin(input logic [3:0] c);
    return 10'(c * 10'h03B) ^ bias;
  endfunction

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    standby_i = 1'b0;
    bias = 10'h000;
    seed = 61271;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_rd(A1, 8'h00);
    chk_rd(A2, 8'h10);
    chk_rd(AL, 8'h00);
    rd(10'h004);
    `CHK(rsp, `ADCS_RESP_SLVERR);
    wr(10'h008, 8'hFF);
    `CHK(wrsp, `ADCS_RESP_SLVERR);
    prev = 10'h000;
    // every time code, restarted while the last result is still unread
    for (int c = 0; c < 8; c++) begin
      ch = 4'($random(seed));
      bias <= 10'($random(seed));
      wr(A1, {3'b001, 1'b0, ch});
      wr(A2, {4'b0001, 3'(c), 1'b0});
      wr(A1, {3'b101, 1'b0, ch});
      t0 = $time;
      n0 = irq_cnt;
      `CHK(channel_select_o, ch);
      chk_rd(AL, {prev[1:0], 6'h10});
      chk_rd(AH, prev[9:2]);
      `CHK(ladder_on_o, 1'b1);
      wait_irq(n0);
      `CHK(ladder_on_o, 1'b0);
      `CHK(int'((t_irq - t0) / 4) inside {[cyc(3'(c)):cyc(3'(c)) + 3]}, 1'b1);
      prev = vin(ch);
      chk_rd(AL, {prev[1:0], 6'h20});
    end
    chk_rd(AH, prev[9:2]);
    chk_rd(AL, {prev[1:0], 6'h00});
    ch = 4'($random(seed));
    wr(A2, 8'h10);
    wr(A1, {3'b011, 1'b0, ch});
    wr(A1, {3'b111, 1'b0, ch});
    wait_irq(irq_cnt);
    t0 = t_irq;
    wait_irq(irq_cnt);
    `CHK(int'((t_irq - t0) / 4), cyc(3'h0));
    prev = vin(ch);
    chk_rd(AL, {prev[1:0], 6'h10});
    wait_irq(irq_cnt);
    bias <= ~bias;
    wr(A1, {3'b000, 1'b0, ch});
    n0 = irq_cnt;
    repeat (100) @(posedge clk_i);
    `CHK(irq_cnt, n0);
    chk_rd(AH, prev[9:2]);
    chk_rd(AL, {prev[1:0], 6'h00});
    // disable and reserved modes never launch
    for (int m = 0; m < 3; m += 2) begin
      wr(A1, {1'b1, 2'(m), 1'b0, ch});
      n0 = irq_cnt;
      repeat (60) @(posedge clk_i);
      `CHK(irq_cnt, n0);
    end
    wr(A1, 8'h00);
    wr(A2, 8'h3C);
    wr(A1, {3'b101, 1'b1, ch});
    repeat (20) @(posedge clk_i);
    `CHK(ladder_on_o, 1'b1);
    `CHK(analog_input_disable_o, 1'b1);
    standby_i <= 1'b1;
    n0 = irq_cnt;
    repeat (3) @(posedge clk_i);
    `CHK(ladder_on_o, 1'b0);
    wr(A1, 8'hA3);
    chk_rd(A1, 8'h00);
    chk_rd(A2, 8'h10);
    chk_rd(AL, 8'h00);
    chk_rd(AH, 8'h00);
    `CHK(analog_input_disable_o, 1'b0);
    standby_i <= 1'b0;
    repeat (1400) @(posedge clk_i);
    `CHK(irq_cnt, n0);
    chk_rd(AL, 8'h00);
    wrap_up();
  end
endmodule // tb_top

// File: verilog/adcs_params.svh
// offsets, field positions, reset values and conversion counts of the sequencer
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH
// register indices; byte address is four times the index
`define ADCS_IDX_CTRL1      8'h0E
`define ADCS_IDX_CTRL2      8'h0F
`define ADCS_IDX_RES_HIGH   8'h25
`define ADCS_IDX_RES_LOW    8'h26
// control register one fields
`define ADCS_C1_START_BIT   7
`define ADCS_C1_MODE_LSB    5
`define ADCS_C1_AIDIS_BIT   4
`define ADCS_C1_CHAN_LSB    0
// control register two fields
`define ADCS_C2_LADDER_BIT  5
`define ADCS_C2_TIME_LSB    1
// mode codes
`define ADCS_MODE_DISABLE   2'h0
`define ADCS_MODE_SOFT      2'h1
`define ADCS_MODE_REPEAT    2'h3
// reset values
`define ADCS_RST_CTRL1      8'h00
`define ADCS_RST_TIME       3'h0
// conversion times in clock periods per time code
`define ADCS_CYC_000        11'd39
`define ADCS_CYC_010        11'd78
`define ADCS_CYC_011        11'd156
`define ADCS_CYC_100        11'd312
`define ADCS_CYC_101        11'd624
`define ADCS_CYC_110        11'd1248
// axi responses
`define ADCS_RESP_OKAY      2'h0
`define ADCS_RESP_SLVERR    2'h2
`endif

// File: verilog/adcs_pkg.sv
// types shared by the conversion sequencer and its approximation engine
package adcs_pkg;
  typedef enum logic [2:0] {
    ADCS_R_NONE,
    ADCS_R_CTRL1,
    ADCS_R_CTRL2,
    ADCS_R_HIGH,
    ADCS_R_LOW
  } adcs_reg_t;

  typedef struct packed {
    logic       start;
    logic       abort;
    logic [10:0] cycles;
  } adcs_cmd_t;

  typedef struct packed {
    logic        run;
    logic        sampling;
    logic [10:0] cnt;
    logic [10:0] lim;
    logic [9:0]  mask;
    logic [9:0]  dac;
    logic [9:0]  result;
    logic        done;
  } adcs_sar_state_t;

  typedef struct packed {
    logic       start_bit;
    logic [1:0] mode;
    logic       in_dis;
    logic [3:0] chan;
    logic       ladder;
    logic [2:0] ctime;
    logic [9:0] result;
    logic       done;
    logic       busy;
    logic       irq;
    logic       ladder_on;
    adcs_cmd_t  cmd;
    logic       aw_got;
    logic [7:0] aw_idx;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcs_state_t;
endpackage

// File: verilog/adcs_sar.sv
// successive-approximation engine: sampling phase, then one bit trial per clock
`include "adcs_params.svh"
module adcs_sar #(
  parameter int RES = 10
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // command from sequencer
  input  wire adcs_pkg::adcs_cmd_t cmd_i,
  // analog side
  input  wire logic              comp_i,
  output logic [9:0]             dac_o,
  output logic                   sampling_o,
  // completion
  output logic                   done_o,
  output logic [9:0]             result_o
);
  if (RES != 10) begin : g_bad_res
    $error("adcs_sar supports RES = 10 only");
  end

  adcs_pkg::adcs_sar_state_t s;
  adcs_pkg::adcs_sar_state_t next_s;
  logic [9:0]                acc;

  always_comb begin
    next_s      = s;
    acc         = comp_i ? s.dac : (s.dac & ~s.mask);
    next_s.done = 1'b0;
    if (cmd_i.abort) begin
      next_s.run      = 1'b0;
      next_s.sampling = 1'b0;
      next_s.mask     = 10'h000;
      next_s.dac      = 10'h000;
    end else if (cmd_i.start) begin
      next_s.run      = 1'b1;
      next_s.sampling = 1'b1;
      next_s.cnt      = 11'h000;
      // command register and result capture take two of the chosen clocks,
      // so busy in the sequencer spans exactly the selected count
      next_s.lim      = cmd_i.cycles - 11'h003;
      next_s.mask     = 10'h000;
      next_s.dac      = 10'h000;
    end else if (s.run) begin
      next_s.cnt = s.cnt + 11'd1;
      if (s.cnt == s.lim - 11'd10) begin
        // last sampling clock: present the msb trial
        next_s.sampling = 1'b0;
        next_s.mask     = 10'h200;
        next_s.dac      = 10'h200;
      end else if (!s.sampling) begin
        next_s.mask = s.mask >> 1;
        next_s.dac  = acc | (s.mask >> 1);
      end
      if (s.cnt == s.lim) begin
        next_s.run    = 1'b0;
        next_s.done   = 1'b1;
        next_s.result = acc;
        next_s.dac    = 10'h000;
        next_s.mask   = 10'h000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dac_o      = s.dac;
  assign sampling_o = s.sampling;
  assign done_o     = s.done;
  assign result_o   = s.result;
endmodule // adcs_sar

// File: verilog/adcs_top.sv
// conversion sequencer with axi4-lite register slave
`include "adcs_params.svh"
// What this block does
// - repeat mode plus start bit begins converting the selected channel
// - completion stores result and raises interrupt together, and sets done flag unless repeat mode relaunches
// - repeat mode relaunches on the same channel after every completion
// - writing disable mode stops a running conversion at once
// - a conversion stopped by disable mode leaves the result registers unchanged
// - software start mode converts once as soon as start bit is set
// - conversion ends after the clock count chosen by time field
// - reading the high result register clears the done flag
// - a new start clears done but keeps the old result until completion
// - standby aborts and returns both control registers to reset values
// - standby entry clears stored results
// - after standby the block stays idle until restarted by software
// - standby disconnects the reference ladder regardless of its control bit
// - each conversion yields a 10-bit unsigned proportional code
// - low-status register holds lower 2 bits, high register upper 8 bits
// - mode decodes 00 disable, 01 software, 10 reserved, 11 repeat
// - start bit clears itself once its conversion has begun
// - busy is one only while converting, cleared on standby
// - time codes select 39 to 1248 clocks; 001 and 111 reserved
module adcs_top #(
  parameter int RES = 10
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // axi4-lite write address and data
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // power mode
  input  wire logic        standby_i,
  // analog side
  input  wire logic        comp_i,
  output logic [3:0]       channel_select_o,
  output logic             analog_input_disable_o,
  output logic [9:0]       dac_code_o,
  output logic             sample_o,
  output logic             ladder_on_o,
  // interrupt
  output logic             conv_done_irq_o
);
  // refuse widths that the trial sequence and the result split cannot serve
  if (RES != 10) begin : g_bad_res
    $error("adcs_top supports RES = 10 only");
  end
  // the shortest time must leave room for sampling and every trial
  if (int'(`ADCS_CYC_000) <= RES + 3) begin : g_bad_cycles
    $error("adcs_top shortest conversion too short for the trials");
  end

  function automatic logic mode_can_run(input logic [1:0] m);
    // reserved code 10 never launches but, unlike disable, lets a running conversion finish
    return (m == `ADCS_MODE_SOFT) || (m == `ADCS_MODE_REPEAT);
  endfunction

  // readback byte per register; unmapped offsets read zero
  function automatic logic [7:0] read_byte(input adcs_pkg::adcs_reg_t   r,
                                           input adcs_pkg::adcs_state_t st);
    logic [7:0] b;
    case (r)
      adcs_pkg::ADCS_R_CTRL1: b = {1'b0, st.mode, st.in_dis, st.chan};
      adcs_pkg::ADCS_R_CTRL2: b = {2'h0, st.ladder, 1'b1, st.ctime, 1'b0};
      adcs_pkg::ADCS_R_HIGH:  b = st.result[9:2];
      adcs_pkg::ADCS_R_LOW:   b = {st.result[1:0], st.done, st.busy, 4'h0};
      default:                b = 8'h00;
    endcase
    return b;
  endfunction

  // write commit; result registers are read-only and drop the data
  function automatic adcs_pkg::adcs_state_t apply_write(input adcs_pkg::adcs_reg_t   r,
                                                        input logic [7:0]          d,
                                                        input adcs_pkg::adcs_state_t st);
    adcs_pkg::adcs_state_t n;
    n = st;
    case (r)
      adcs_pkg::ADCS_R_CTRL1: begin
        n.start_bit = d[`ADCS_C1_START_BIT];
        n.mode      = d[`ADCS_C1_MODE_LSB +: 2];
        n.in_dis    = d[`ADCS_C1_AIDIS_BIT];
        n.chan      = d[`ADCS_C1_CHAN_LSB +: 4];
      end
      adcs_pkg::ADCS_R_CTRL2: begin
        n.ladder = d[`ADCS_C2_LADDER_BIT];
        n.ctime  = d[`ADCS_C2_TIME_LSB +: 3];
      end
      default: n = st;
    endcase
    return n;
  endfunction

  // standby returns both control registers to reset and drops the results
  function automatic adcs_pkg::adcs_state_t standby_clear(input adcs_pkg::adcs_state_t st);
    adcs_pkg::adcs_state_t n;
    logic [7:0]            c1;
    n  = st;
    c1 = `ADCS_RST_CTRL1;
    n.cmd.abort = 1'b1;
    n.cmd.start = 1'b0;
    n.busy      = 1'b0;
    n.irq       = 1'b0;
    n.start_bit = c1[`ADCS_C1_START_BIT];
    n.mode      = c1[`ADCS_C1_MODE_LSB +: 2];
    n.in_dis    = c1[`ADCS_C1_AIDIS_BIT];
    n.chan      = c1[`ADCS_C1_CHAN_LSB +: 4];
    n.ladder    = 1'b0;
    n.ctime     = `ADCS_RST_TIME;
    n.result    = 10'h000;
    n.done      = 1'b0;
    return n;
  endfunction

  function automatic adcs_pkg::adcs_reg_t decode(input logic [9:0] addr);
    adcs_pkg::adcs_reg_t r;
    r = adcs_pkg::ADCS_R_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[9:2])
        `ADCS_IDX_CTRL1:    r = adcs_pkg::ADCS_R_CTRL1;
        `ADCS_IDX_CTRL2:    r = adcs_pkg::ADCS_R_CTRL2;
        `ADCS_IDX_RES_HIGH: r = adcs_pkg::ADCS_R_HIGH;
        `ADCS_IDX_RES_LOW:  r = adcs_pkg::ADCS_R_LOW;
        default:            r = adcs_pkg::ADCS_R_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [10:0] conv_cycles(input logic [2:0] code);
    logic [10:0] c;
    case (code)
      3'h0:    c = `ADCS_CYC_000;
      3'h2:    c = `ADCS_CYC_010;
      3'h3:    c = `ADCS_CYC_011;
      3'h4:    c = `ADCS_CYC_100;
      3'h5:    c = `ADCS_CYC_101;
      3'h6:    c = `ADCS_CYC_110;
      // reserved codes fall back to the longest, safest time
      default: c = `ADCS_CYC_110;
    endcase
    return c;
  endfunction

  adcs_pkg::adcs_state_t s;
  adcs_pkg::adcs_state_t next_s;
  adcs_pkg::adcs_reg_t   wr_reg;
  adcs_pkg::adcs_reg_t   rd_reg;
  logic                  sar_done;
  logic [9:0]            sar_result;
  logic                  do_write;
  logic                  do_read;
  logic                  launch;
  logic [7:0]            rbyte;

  adcs_sar #(
    .RES (RES)
  ) u_sar (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .cmd_i      (s.cmd),
    .comp_i     (comp_i),
    .dac_o      (dac_code_o),
    .sampling_o (sample_o),
    .done_o     (sar_done),
    .result_o   (sar_result)
  );

  always_comb begin
    next_s = s;
    wr_reg = decode({s.aw_idx, 2'h0});
    rd_reg = decode(s_axi_araddr);
    rbyte  = 8'h00;
    launch = 1'b0;
    next_s.irq       = 1'b0;
    next_s.cmd.start = 1'b0;
    next_s.cmd.abort = 1'b0;

    // write channel capture, either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = s_axi_awaddr[9:2];
      if (s_axi_awaddr[1:0] != 2'h0) begin
        next_s.aw_idx = 8'hFF;
      end
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata[7:0];
      next_s.w_lane = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // commit waits until both halves are in and the last answer has gone
    do_write = s.aw_got && s.w_got && !s.bvalid;
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = (wr_reg == adcs_pkg::ADCS_R_NONE) ? `ADCS_RESP_SLVERR
                                                        : `ADCS_RESP_OKAY;
      // control registers accept no data during standby
      if (s.w_lane && !standby_i) begin
        next_s = apply_write(wr_reg, s.w_data, next_s);
      end
    end

    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    do_read = s_axi_arvalid && s.arready;
    if (do_read) begin
      rbyte         = read_byte(rd_reg, s);
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h00_0000, rbyte};
      next_s.rresp  = (rd_reg == adcs_pkg::ADCS_R_NONE) ? `ADCS_RESP_SLVERR
                                                        : `ADCS_RESP_OKAY;
      if (rd_reg == adcs_pkg::ADCS_R_HIGH) begin
        next_s.done = 1'b0;
      end
    end

    // sequencing; mode 10 is reserved and never launches
    if (!s.busy && s.start_bit && !standby_i &&
        mode_can_run(s.mode)) begin
      launch = 1'b1;
    end
    if (s.busy && sar_done) begin
      next_s.result = sar_result;
      next_s.done   = 1'b1;
      next_s.irq    = 1'b1;
      next_s.busy   = 1'b0;
      if (s.mode == `ADCS_MODE_REPEAT) begin
        launch = 1'b1;
      end
    end
    // a running conversion that sees disable mode ends without storing
    if (s.busy && s.mode == `ADCS_MODE_DISABLE && !sar_done) begin
      next_s.busy      = 1'b0;
      next_s.cmd.abort = 1'b1;
    end
    if (launch && mode_can_run(s.mode)) begin
      next_s.busy       = 1'b1;
      next_s.start_bit  = 1'b0;
      next_s.cmd.start  = 1'b1;
      next_s.cmd.cycles = conv_cycles(s.ctime);
      // old result stays until this conversion finishes; the done set of a
      // completion in this same cycle is overridden by the relaunch
      next_s.done       = 1'b0;
    end

    if (standby_i) begin
      next_s = standby_clear(next_s);
    end

    // ladder follows its control bit or a running conversion, never standby
    next_s.ladder_on = !standby_i && (next_s.ladder || next_s.busy);
    next_s.awready   = !next_s.aw_got && !next_s.bvalid;
    next_s.wready    = !next_s.w_got && !next_s.bvalid;
    next_s.arready   = !next_s.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready          = s.awready;
  assign s_axi_wready           = s.wready;
  assign s_axi_bvalid           = s.bvalid;
  assign s_axi_bresp            = s.bresp;
  assign s_axi_arready          = s.arready;
  assign s_axi_rvalid           = s.rvalid;
  assign s_axi_rdata            = s.rdata;
  assign s_axi_rresp            = s.rresp;
  assign channel_select_o       = s.chan;
  assign analog_input_disable_o = s.in_dis;
  assign ladder_on_o            = s.ladder_on;
  assign conv_done_irq_o        = s.irq;
endmodule // adcs_top
